// ==== port_power_pin_control.sv ====
// Pin qualification, power state and flag outputs of the port power controller
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - Polarity select high makes power enable active high, low makes it active low.
// - Polarity select is captured once after power-up; later changes are ignored.
// - Outside stand-alone mode the captured polarity also picks the serial address.
// - Modes and emulation all zero with enable asserted turns detection off.
// - Serial mode with ignore-pins drops mode pins, else config bits join pins.
// - Port switch never closes while enable is inactive.
// - Serial mode with ignore-pins drops enable pin, else config bit joins pin.
// - Fault hold comes from pin stand-alone, from config bit in serial mode.
// - Detect enable one needs attach before switching on; zero disables detection.
// - Detect enable from config bit in serial mode, pin otherwise; serial off.
// - Interrupt output pulls low on error, unless masked; unmasked by default.
// - Interrupt also on linked low-current or thermal flag and rationing threshold.
// - Interrupt releases only when every asserting condition is gone.
// - Attach flag set on attach, held until Sleep or removal.
// - Detect enable zero in Active asserts attach flag regardless of device.
// - Attach flag toggles when detect enabled, bypass overloaded, enable on, source absent.
// - Charging flag asserted while charging active, released when it ends.
// - Interrupt, attach and charging flags stay off during power-up blanking.
// - Error must persist past mask time before interrupt; thermal shutdown immediate.
// - Data switch closed in Active, open in emulation, dedicated, Detect, Sleep; dataSwitchInDedicated keeps it closed in dedicated.
// - Data switch forced open while core supply is low.
// - Port switch on throughout Active except while discharging or enable is inactive.
// - Limit code and bus mode read once at power-up; eight limit codes.
module port_power_pin_control
  import port_power_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Asynchronous pin and comparator inputs
  input  wire pins_t       pinsIn,
  // Open-drain flags, driven low while enable is high
  output logic             alertOut,
  output logic             alertOe,
  output logic             attachFlagOut,
  output logic             attachFlagOe,
  output logic             chargingFlagOut,
  output logic             chargingFlagOe,
  // Switch controls, captured settings and the live fault hold
  output logic             portSwitchOn,
  output logic             dataSwitchClosed,
  output logic             faultLatchMode,
  output logic             serialAddrSel,
  output logic             serialActive,
  output logic [2:0]       currentLimitCode
);

  // Elaboration check: every timing figure must fit the shared counter width
  if (LIMIT_CODES != 8 || MASK_CYC >= (1 << CNT_W) || CYCLE_CYC >= (1 << CNT_W)
      || BLANK_CYC >= (1 << CNT_W) || TOGGLE_CYC >= (1 << CNT_W)) begin : g_width_bad
    $error("port_power_pin_control: counter width too small for timing");
  end

  // All block state
  typedef struct packed {
    pins_t             syncA;
    pins_t             syncB;
    logic              captured;
    logic [1:0]        warm;
    logic              polarity;
    logic              busSerial;
    logic [2:0]        limitCode;
    pstate_t           state;
    logic              attached;
    logic [CNT_W-1:0]  blankCnt;
    logic [CNT_W-1:0]  maskCnt;
    logic [CNT_W-1:0]  cycleCnt;
    logic [CNT_W-1:0]  toggleCnt;
    logic              toggleBit;
    logic              prevEnable;
    logic              enableToggled;
    logic              restartReq;
    ctrl_t             ctrl;
    logic [31:0]       rdata;
    logic              rerr;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // Qualified controls
  pins_t p;
  logic  enPin;
  logic  enEff;
  logic  modeA;
  logic  modeB;
  logic  emuEn;
  logic  detEn;
  logic  allZero;
  logic  errQual;
  logic  goActive;
  logic  blanking;
  logic  errClear;
  logic  alertSrc;
  logic  setupPhase;

  always_comb begin
    p          = s_ff.syncB;  // Only the second stage is ever read
    blanking   = !s_ff.captured || (s_ff.blankCnt != '0);
    enPin      = s_ff.polarity ? p.portPowerEnable : !p.portPowerEnable;
    if (s_ff.busSerial && s_ff.ctrl.ignorePinsCfg) begin
      enEff = s_ff.ctrl.powerEnableCfg;
      modeA = s_ff.ctrl.modeCtlACfg;
      modeB = s_ff.ctrl.modeCtlBCfg;
      emuEn = s_ff.ctrl.emulationEnableCfg;
    end else if (s_ff.busSerial) begin
      enEff = enPin | s_ff.ctrl.powerEnableCfg;
      modeA = p.modeCtlA | s_ff.ctrl.modeCtlACfg;
      modeB = p.modeCtlB | s_ff.ctrl.modeCtlBCfg;
      emuEn = p.emulationEnable | s_ff.ctrl.emulationEnableCfg;
    end else begin
      enEff = enPin;
      modeA = p.modeCtlA;
      modeB = p.modeCtlB;
      emuEn = p.emulationEnable;
    end
    detEn    = s_ff.busSerial ? s_ff.ctrl.detectEnableCfg : p.detectEnable;
    allZero  = !(modeA | modeB | emuEn);
    // Persistence: must exceed the mask time, thermal shutdown bypasses it
    errQual  = (p.errCond && (s_ff.maskCnt == CNT_W'(MASK_CYC))) || p.thermalShut;
    goActive = p.sourceOk && enEff && !allZero && (!detEn || s_ff.attached);
    errClear = !p.errCond && !p.thermalShut;
    setupPhase = psel && !penable;
  end

  // Next-state logic for the whole block
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.syncA    = pinsIn;
    nxt_s.syncB    = s_ff.syncA;

    // Straps sampled once the synchroniser holds real pin levels, not its reset zeros
    nxt_s.warm     = {s_ff.warm[0], 1'b1};
    if (!s_ff.captured && s_ff.warm[1]) begin
      nxt_s.captured  = 1'b1;
      nxt_s.polarity  = p.polaritySel;
      nxt_s.busSerial = p.busSerialSel;
      nxt_s.limitCode = p.limitCode;
    end

    if (s_ff.captured && s_ff.blankCnt != '0) begin
      nxt_s.blankCnt = s_ff.blankCnt - CNT_W'(1);
    end

    // Error persistence counter saturates at the mask time
    if (!p.errCond) begin
      nxt_s.maskCnt = '0;
    end else if (s_ff.maskCnt != CNT_W'(MASK_CYC)) begin
      nxt_s.maskCnt = s_ff.maskCnt + CNT_W'(1);
    end

    // Enable toggle memory, used to rearm a latched fault
    nxt_s.prevEnable = enEff;
    if (s_ff.state != P_ERROR) begin
      nxt_s.enableToggled = 1'b0;
    end else if (s_ff.prevEnable && !enEff) begin
      nxt_s.enableToggled = 1'b1;
    end

    // Attach memory: a new attach wins over a removal in the same cycle
    if (!detEn || (allZero && enEff) || s_ff.state == P_SLEEP) begin
      nxt_s.attached = 1'b0;
    end else if (p.attachEvt && s_ff.state == P_DETECT) begin
      nxt_s.attached = 1'b1;
    end else if (p.removalEvt) begin
      nxt_s.attached = 1'b0;
    end

    // Attach flag cycling while the bypass path is overloaded
    if (detEn && enEff && !p.sourceOk && p.bypassOver) begin
      if (s_ff.toggleCnt == CNT_W'(TOGGLE_CYC - 1)) begin
        nxt_s.toggleCnt = '0;
        nxt_s.toggleBit = !s_ff.toggleBit;
      end else begin
        nxt_s.toggleCnt = s_ff.toggleCnt + CNT_W'(1);
      end
    end else begin
      nxt_s.toggleCnt = '0;
      nxt_s.toggleBit = 1'b0;
    end

    // Power state sequencing
    case (s_ff.state)
      P_SLEEP, P_DETECT, P_ACTIVE: begin
        if (!s_ff.captured) begin
          nxt_s.state = P_SLEEP;
        end else if (errQual && s_ff.state == P_ACTIVE) begin
          nxt_s.state = P_ERROR;
        end else if (p.thermalShut && s_ff.state == P_DETECT) begin
          nxt_s.state = P_ERROR;
        end else if (goActive) begin
          nxt_s.state = P_ACTIVE;
        end else if (detEn && !(allZero && enEff)) begin
          nxt_s.state = P_DETECT;
        end else begin
          nxt_s.state = P_SLEEP;
        end
        nxt_s.cycleCnt = '0;
      end
      P_ERROR: begin
        if (s_ff.cycleCnt != CNT_W'(CYCLE_CYC)) begin
          nxt_s.cycleCnt = s_ff.cycleCnt + CNT_W'(1);
        end
        // Latched faults wait for software, an enable toggle or a removal
        if (errClear && (faultLatchMode
            ? (s_ff.restartReq || s_ff.enableToggled || p.removalEvt)
            : (s_ff.cycleCnt == CNT_W'(CYCLE_CYC) || p.removalEvt))) begin
          nxt_s.state      = P_SLEEP;
          nxt_s.restartReq = 1'b0;
        end
      end
      default: begin
        nxt_s.state = P_SLEEP;
      end
    endcase
    if (s_ff.state != P_ERROR) begin
      nxt_s.restartReq = 1'b0;
    end

    // APB: decode in setup, effect at the access edge
    if (setupPhase) begin
      nxt_s.rerr  = 1'b0;
      nxt_s.rdata = '0;
      case (paddr)
        CTRL_OFS: begin
          nxt_s.rdata = {20'h00000, s_ff.ctrl};
          nxt_s.rerr  = pwrite && !s_ff.busSerial;
        end
        CMD_OFS: begin
          nxt_s.rerr  = pwrite && !s_ff.busSerial;
        end
        STATUS_OFS: begin
          nxt_s.rdata = {16'h0000, s_ff.limitCode, s_ff.busSerial, s_ff.polarity,
                         s_ff.attached, detEn, enEff, alertOe, attachFlagOe,
                         chargingFlagOe, portSwitchOn, dataSwitchClosed,
                         faultLatchMode, s_ff.state};
          nxt_s.rerr  = pwrite;
        end
        default: begin
          nxt_s.rerr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && !s_ff.rerr) begin
      if (paddr == CTRL_OFS) begin
        nxt_s.ctrl = ctrl_t'(pwdata[11:0]);
      end
      if (paddr == CMD_OFS && pwdata[CMD_RESTART_BIT] && s_ff.state == P_ERROR) begin
        nxt_s.restartReq = 1'b1;
      end
    end
  end

  // One register stage for all state, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff          <= '0;
      s_ff.state    <= P_SLEEP;
      s_ff.blankCnt <= CNT_W'(BLANK_CYC);
      s_ff.ctrl     <= ctrl_t'(CTRL_RESET);
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // Interrupt sources; the mask hides errors only, linked flags still pull
  assign alertSrc = (!s_ff.ctrl.alertMask
                     && ((s_ff.state == P_ERROR) || (p.thermalShut && s_ff.captured)))
                  || (p.lowCurrent && s_ff.ctrl.linkLowCurrent)
                  || (p.thermalReg && s_ff.ctrl.linkThermal)
                  || (p.rationHit && s_ff.ctrl.rationAlert);

  // Flag outputs: pin levels are always low, enables pull
  assign alertOut        = 1'b0;
  assign attachFlagOut   = 1'b0;
  assign chargingFlagOut = 1'b0;
  assign alertOe         = !blanking && alertSrc;
  assign attachFlagOe    = !blanking && ((detEn && s_ff.attached)
                         || (!detEn && s_ff.state == P_ACTIVE)
                         || s_ff.toggleBit);
  assign chargingFlagOe  = !blanking && p.charging;

  // Switch controls from the power state
  assign portSwitchOn     = (s_ff.state == P_ACTIVE) && enEff && !p.discharging;
  assign dataSwitchClosed = (s_ff.state == P_ACTIVE) && !p.coreLow && !p.emuNonCdp
                          && (!p.dedCharge || s_ff.ctrl.dataSwitchInDedicated);

  // Captured settings, and the fault hold taken live from its pin or config bit
  assign faultLatchMode   = s_ff.busSerial ? s_ff.ctrl.faultHoldCfg : p.faultHold;
  assign serialAddrSel    = s_ff.busSerial && s_ff.polarity;
  assign serialActive     = s_ff.busSerial;
  assign currentLimitCode = s_ff.limitCode;

  // APB answers with no wait state unless the block is frozen
  assign pready  = ce;
  assign prdata  = s_ff.rdata;
  assign pslverr = s_ff.rerr;

  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (rst);

  chk_switch_needs_enable: assert property (portSwitchOn |-> enEff)
    else $error("port switch closed with enable inactive");
  chk_blank_quiet_flags: assert property (
      blanking |-> !alertOe && !attachFlagOe && !chargingFlagOe)
    else $error("flag asserted during blanking");
  chk_polarity_frozen: assert property (
      s_ff.captured |=> $stable(s_ff.polarity) && $stable(s_ff.limitCode))
    else $error("captured strap changed after power-up");
  chk_data_state_gate: assert property (
      dataSwitchClosed |-> s_ff.state == P_ACTIVE && !p.coreLow)
    else $error("data switch closed outside Active or with core low");
  chk_mask_before_err: assert property (
      (s_ff.state == P_ACTIVE && !p.thermalShut && p.errCond) ##1 (s_ff.state == P_ERROR)
      |-> $past(s_ff.maskCnt) == CNT_W'(MASK_CYC))
    else $error("error entered before mask time elapsed");
  chk_fault_source: assert property (
      faultLatchMode == (s_ff.busSerial ? s_ff.ctrl.faultHoldCfg : p.faultHold))
    else $error("fault hold taken from wrong source");
  chk_free_attach_flag: assert property (
      !blanking && !detEn && s_ff.state == P_ACTIVE |-> attachFlagOe)
    else $error("attach flag not asserted in Active without detection");
  chk_alert_release: assert property (
      alertOe |-> ((s_ff.state == P_ERROR || p.thermalShut) && !s_ff.ctrl.alertMask)
      || (p.lowCurrent && s_ff.ctrl.linkLowCurrent) || (p.thermalReg && s_ff.ctrl.linkThermal)
      || (p.rationHit && s_ff.ctrl.rationAlert))
    else $error("alert asserted with no source");
  chk_zero_modes_nodet: assert property (allZero && enEff |=> !s_ff.attached)
    else $error("detection stayed active with all modes zero");
  chk_active_switch_on: assert property (
      s_ff.state == P_ACTIVE && enEff && !p.discharging |-> portSwitchOn)
    else $error("port switch off in Active without discharge");

  cov_enter_active: cover property (s_ff.state == P_DETECT ##1 s_ff.state == P_ACTIVE);
  cov_enter_error: cover property (s_ff.state == P_ACTIVE ##1 s_ff.state == P_ERROR);
  cov_recover_error: cover property (s_ff.state == P_ERROR ##1 s_ff.state == P_SLEEP);
  cov_attach_toggle: cover property ($rose(s_ff.toggleBit));

endmodule

// ==== port_power_pkg.sv ====
// Shared constants, types and register map of the port power pin control block
package port_power_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 50;

  // Timing figures in their own unit
  localparam int BLANK_NS      = 10000;  // Power-up flag blanking, upper bound
  localparam int MASK_NS       = 5000;   // Error persistence before alert
  localparam int CYCLE_NS      = 150000; // Auto-recovery retry period
  localparam int TOGGLE_NS     = 3200;   // Attach flag toggle half period

  // Cycle counts: longest times round down, least times round up
  localparam int BLANK_CYC     = (BLANK_NS / CLK_PERIOD_NS < 1) ? 1 : BLANK_NS / CLK_PERIOD_NS;
  localparam int MASK_CYC      = (MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC     = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOGGLE_CYC    = (TOGGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Command register fields
  localparam int CMD_RESTART_BIT = 0;

  // Control register reset value: alerts unmasked, rationing alert on
  localparam logic [11:0] CTRL_RESET = 12'h800;

  // Number of hardware current limit codes
  localparam int LIMIT_CODES = 8;

  // Power states
  typedef enum logic [1:0] {
    P_SLEEP,
    P_DETECT,
    P_ACTIVE,
    P_ERROR
  } pstate_t;

  // Software control bits, bit 0 at the bottom
  typedef struct packed {
    logic rationAlert;         // 11
    logic linkThermal;         // 10
    logic linkLowCurrent;      // 9
    logic alertMask;           // 8
    logic dataSwitchInDedicated; // 7
    logic detectEnableCfg;     // 6
    logic faultHoldCfg;        // 5
    logic powerEnableCfg;      // 4
    logic emulationEnableCfg;  // 3
    logic modeCtlBCfg;         // 2
    logic modeCtlACfg;         // 1
    logic ignorePinsCfg;       // 0
  } ctrl_t;

  // Asynchronous inputs from pins and analog comparators
  typedef struct packed {
    logic       polaritySel;
    logic       portPowerEnable;
    logic       modeCtlA;
    logic       modeCtlB;
    logic       emulationEnable;
    logic       detectEnable;
    logic       faultHold;
    logic       busSerialSel;
    logic [2:0] limitCode;
    logic       sourceOk;
    logic       coreLow;
    logic       errCond;
    logic       thermalShut;
    logic       attachEvt;
    logic       removalEvt;
    logic       discharging;
    logic       bypassOver;
    logic       charging;
    logic       lowCurrent;
    logic       thermalReg;
    logic       rationHit;
    logic       emuNonCdp;
    logic       dedCharge;
  } pins_t;

endpackage

// ==== host_model.sv ====
// Host-side pin driver and open-drain flag resolver for the port power block
`timescale 1ns/1ps
module host_model
  import port_power_pkg::*;
(
  // Clock
  input  wire logic  clk,
  // Levels the bench asks for, and the block's pin inputs
  input  wire pins_t want,
  output pins_t      pinsOut,
  // Pull-down enables from the block
  input  wire logic  alertOe,
  input  wire logic  attachOe,
  input  wire logic  chargingOe,
  // Resolved flag lines as the host sees them
  output logic       alertN,
  output logic       attachN,
  output logic       chargingN
);
  pins_t heldQ = '0;

  // Host logic moves its pins just after an edge, never mid-cycle
  always @(posedge clk) begin
    heldQ <= want;
  end
  assign pinsOut = heldQ;

  // Pull-ups win whenever the block lets go of a line
  assign alertN    = alertOe ? 1'b0 : 1'b1;
  assign attachN   = attachOe ? 1'b0 : 1'b1;
  assign chargingN = chargingOe ? 1'b0 : 1'b1;
endmodule

// ==== tb.sv ====
// Self-checking bench for the port power pin control block
`timescale 1ns/1ps
module tb;
  import port_power_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  pins_t       want, pinsIn;
  logic        alertOe, attachOe, chargingOe, alertN, attachN, chargingN;
  logic        portSwitchOn, dataSwitchClosed, faultLatchMode, serialAddrSel, serialActive;
  logic [2:0]  currentLimitCode;
  int          badCount = 0;
  int          checked = 0;
  int          cycles = 0;

  port_power_pin_control dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pinsIn(pinsIn), .alertOut(), .alertOe(alertOe), .attachFlagOut(),
    .attachFlagOe(attachOe), .chargingFlagOut(), .chargingFlagOe(chargingOe),
    .portSwitchOn(portSwitchOn), .dataSwitchClosed(dataSwitchClosed),
    .faultLatchMode(faultLatchMode), .serialAddrSel(serialAddrSel),
    .serialActive(serialActive), .currentLimitCode(currentLimitCode));

  host_model host (.clk(clk), .want(want), .pinsOut(pinsIn), .alertOe(alertOe),
    .attachOe(attachOe), .chargingOe(chargingOe), .alertN(alertN), .attachN(attachN),
    .chargingN(chargingN));

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("Counts: %0d checked, %0d bad", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Straps must sit on the pins while reset is held so the capture sees them
  task automatic do_reset(input logic pol, input logic ser, input logic [2:0] code);
    rst <= 1'b1;
    want.polaritySel <= pol;
    want.busSerialSel <= ser;
    want.limitCode <= code;
    wt(12);
    rst <= 1'b0;
  endtask

  task automatic t_powerup();
    do_reset(1'b1, 1'b0, 3'h5);
    wt(8);
    chk(portSwitchOn, 1'b1);
    chk(attachN, 1'b1);
    wt(BLANK_CYC);
    chk(attachN, 1'b0);
    chk(dataSwitchClosed, 1'b1);
    chk({serialActive, currentLimitCode}, 4'h5);
  endtask

  task automatic t_polarity();
    want.polaritySel <= 1'b0;
    wt(8);
    chk(portSwitchOn, 1'b1);
    want.portPowerEnable <= 1'b0;
    wt(8);
    chk(portSwitchOn, 1'b0);
    chk(dataSwitchClosed, 1'b0);
    chk(attachN, 1'b1);
    want.portPowerEnable <= 1'b1;
    wt(8);
  endtask

  task automatic t_side();
    want.discharging <= 1'b1;
    wt(8);
    chk(portSwitchOn, 1'b0);
    want.discharging <= 1'b0;
    want.coreLow <= 1'b1;
    wt(8);
    chk(dataSwitchClosed, 1'b0);
    want.coreLow <= 1'b0;
    want.dedCharge <= 1'b1;
    wt(8);
    chk(dataSwitchClosed, 1'b0);
    want.dedCharge <= 1'b0;
    want.modeCtlA <= 1'b0;
    wt(8);
    chk(portSwitchOn, 1'b0);
    want.modeCtlA <= 1'b1;
    wt(8);
  endtask

  // Latched fault: no alert halfway through the mask time, long error latched until enable toggles
  task automatic t_fault();
    chk(portSwitchOn, 1'b1);
    chk(faultLatchMode, 1'b1);
    want.errCond <= 1'b1;
    wt(MASK_CYC / 2);
    chk(alertN, 1'b1);
    wt(MASK_CYC);
    chk(alertN, 1'b0);
    want.errCond <= 1'b0;
    wt(20);
    chk(portSwitchOn, 1'b0);
    want.portPowerEnable <= 1'b0;
    wt(8);
    want.portPowerEnable <= 1'b1;
    wt(12);
    chk(alertN, 1'b1);
    chk(portSwitchOn, 1'b1);
  endtask

  task automatic t_thermal();
    want.faultHold <= 1'b0;
    want.thermalShut <= 1'b1;
    wt(6);
    chk(alertN, 1'b0);
    chk(faultLatchMode, 1'b0);
    want.thermalShut <= 1'b0;
    wt(CYCLE_CYC + 20);
    chk(alertN, 1'b1);
    chk(portSwitchOn, 1'b1);
  endtask

  task automatic t_apb_alone();
    apb(1'b1, CTRL_OFS, 32'h0000_0811);
    chk(err, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk({err, rd[15:11]}, 6'h15);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(err, 1'b1);
  endtask

  // Serial-bus mode with active-low enable; detect and fault pins must be ignored
  task automatic t_serial_power();
    want.portPowerEnable <= 1'b0;
    want.detectEnable <= 1'b1;
    want.faultHold <= 1'b1;
    wt(1);
    do_reset(1'b0, 1'b1, 3'h3);
    wt(BLANK_CYC + 10);
    chk({serialActive, serialAddrSel, currentLimitCode}, 5'h13);
    chk(portSwitchOn, 1'b1);
    chk(faultLatchMode, 1'b0);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, CTRL_RESET);
  endtask

  task automatic t_serial_cfg();
    apb(1'b1, CTRL_OFS, 32'h0000_0801);
    wt(8);
    chk(portSwitchOn, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0811);
    wt(8);
    chk(portSwitchOn, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0851);
    wt(8);
    apb(1'b1, CTRL_OFS, 32'h0000_0873);
    wt(8);
    chk({portSwitchOn, attachN, faultLatchMode}, 3'h3);
    want.attachEvt <= 1'b1;
    wt(1);
    want.attachEvt <= 1'b0;
    wt(8);
    chk({portSwitchOn, attachN}, 2'h2);
    want.removalEvt <= 1'b1;
    wt(1);
    want.removalEvt <= 1'b0;
    wt(8);
    chk(attachN, 1'b1);
  endtask

  // Bypass overload with no source: attach flag flips every toggle half period
  task automatic t_toggle();
    want.sourceOk <= 1'b0;
    want.bypassOver <= 1'b1;
    wt(8);
    chk(attachN, 1'b1);
    wt(TOGGLE_CYC);
    chk(attachN, 1'b0);
    wt(TOGGLE_CYC);
    chk(attachN, 1'b1);
    want.sourceOk <= 1'b1;
    want.bypassOver <= 1'b0;
    wt(8);
  endtask

  task automatic t_flags();
    apb(1'b1, CTRL_OFS, 32'h0000_0a33);
    wt(8);
    want.charging <= 1'b1;
    wt(6);
    chk(chargingN, 1'b0);
    want.charging <= 1'b0;
    want.lowCurrent <= 1'b1;
    wt(6);
    chk({chargingN, alertN}, 2'h2);
    want.lowCurrent <= 1'b0;
    wt(6);
    chk(alertN, 1'b1);
    want.rationHit <= 1'b1;
    wt(6);
    chk(alertN, 1'b0);
    want.rationHit <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_0933);
    want.errCond <= 1'b1;
    wt(MASK_CYC + 20);
    chk({alertN, portSwitchOn}, 2'h2);
    apb(1'b1, STATUS_OFS, 32'h0000_0000);
    chk(err, 1'b1);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = '0;
    want.portPowerEnable = 1'b1;
    want.modeCtlA = 1'b1;
    want.sourceOk = 1'b1;
    want.faultHold = 1'b1;
    t_powerup();
    t_polarity();
    t_side();
    t_fault();
    t_thermal();
    t_apb_alone();
    t_serial_power();
    t_serial_cfg();
    t_toggle();
    t_flags();
    printVerdict();
  end
endmodule
